// ### src/fxe_extract.sv
`timescale 1ns/1ps
`default_nettype none
module fxe_extract #(
    parameter int unsigned W = 32
) (
    // Operands
    input  wire logic [W-1:0] src_dst,
    input  wire logic [W-1:0] bitpos,
    input  wire logic [W-1:0] len,
    // Result
    output logic      [W-1:0] result
);
    // Shift by bit position modulo 32, only low five bits count
    wire logic [4:0]   shift_amt = bitpos[4:0];
    wire logic [W-1:0] shifted   = src_dst >> shift_amt;
    // A length of 32 or more keeps the whole word
    wire logic         len_big   = |len[W-1:5];
    wire logic [W-1:0] field_mask = len_big ? {W{1'b1}} : ~({W{1'b1}} << len[4:0]);
    assign result = shifted & field_mask;
endmodule
`default_nettype wire

// ### src/fxe_fault_cond.sv
`timescale 1ns/1ps
`default_nettype none
module fxe_fault_cond (
    // Inputs
    input  wire logic [2:0] opcode_low,
    input  wire logic [2:0] arith_condition_bits,
    // Result
    output logic            raise
);
    wire logic [2:0] cond_mask = opcode_low;
    wire logic       is_unord  = (cond_mask == fxe_pkg::MASK_UNORDERED);
    // and fault test; encoding; ordered handled
    assign raise = is_unord ? (arith_condition_bits == 3'h0)
                            : |(cond_mask & arith_condition_bits);
endmodule
`default_nettype wire

// ### src/fxe_pkg.sv
package fxe_pkg;
    // Datapath width
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned SHIFT_W     = 5;
    // Condition mask field position inside the opcode
    localparam int unsigned MASK_LSB    = 0;
    localparam int unsigned MASK_W      = 3;
    // Trace enable bit position in the process controls
    localparam int unsigned TRACE_EN_POS = 0;
    // Condition mask encodings
    localparam logic [2:0] MASK_UNORDERED = 3'h0;
    localparam logic [2:0] MASK_GREATER   = 3'h1;
    localparam logic [2:0] MASK_EQUAL     = 3'h2;
    localparam logic [2:0] MASK_GE        = 3'h3;
    localparam logic [2:0] MASK_LESS      = 3'h4;
    localparam logic [2:0] MASK_NE        = 3'h5;
    localparam logic [2:0] MASK_LE        = 3'h6;
    localparam logic [2:0] MASK_ORDERED   = 3'h7;
    // Local register cache geometry
    localparam int unsigned NUM_SETS    = 4;
    localparam int unsigned REGS_PER_SET = 16;
    localparam int unsigned SET_W       = 2;
    localparam int unsigned REG_W       = 4;
    // Reset values
    localparam logic [31:0] RESET_DATA  = 32'h0000_0000;
    // Operation codes on the command port
    typedef enum logic [2:0] {
        FXE_OP_NONE,
        FXE_OP_EXTRACT,
        FXE_OP_FAULT,
        FXE_OP_FLUSH,
        FXE_OP_FMARK,
        FXE_OP_RETURN
    } fxe_op_type;
endpackage

// ### src/fxe_top.sv
// Overview of operation
// - Field pull shifts right by position mod 32, keeps width bits, zero-fills.
// - Conditional fault raises range fault when condition AND mask is nonzero.
// - Unordered variant faults only when condition bits are all zero.
// - Condition mask comes from opcode bits 0 to 2.
// - Mask encodings cover unordered through ordered, eight values.
// - Ordered and unordered variants are decoded and supported.
// - Spill writes every cached set except current to its frame.
// - After spill writes, whole local cache is marked purged.
// - Return to uncached frame reloads locals from memory first.
// - Forced marker raises trace fault whenever trace enable bit is set.
`timescale 1ns/1ps
`default_nettype none
module fxe_top #(
    parameter int unsigned NUM_SETS     = fxe_pkg::NUM_SETS,
    parameter int unsigned REGS_PER_SET = fxe_pkg::REGS_PER_SET
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Command port
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire fxe_pkg::fxe_op_type cmd_op,
    input  wire logic [7:0]  cmd_opcode,
    input  wire logic [31:0] cmd_src_dst,
    input  wire logic [31:0] cmd_bitpos,
    input  wire logic [31:0] cmd_len,
    input  wire logic [31:0] cmd_return_frame,
    // Core state
    input  wire logic [2:0]  arith_condition_bits,
    input  wire logic [31:0] process_controls,
    input  wire logic [1:0]  current_set,
    // Results
    output logic             done,
    output logic [31:0]      result_data,
    output logic             result_we,
    output logic             range_fault,
    output logic             mark_trace_fault,
    // Cache fill interface from core
    input  wire logic        fill_we,
    input  wire logic [1:0]  fill_set,
    input  wire logic [3:0]  fill_reg,
    input  wire logic [31:0] fill_data,
    input  wire logic [31:0] fill_frame,
    // Memory port
    output logic             mem_req,
    output logic             mem_write,
    output logic [31:0]      mem_addr,
    output logic [31:0]      mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    // Cache status
    output logic [3:0]       set_valid_out
);
    // Spill and reload walk states
    typedef enum logic [2:0] {
        ST_IDLE, ST_FLUSH_SCAN, ST_FLUSH_WR, ST_RELOAD_RD, ST_DONE
    } fxe_state_type;

    fxe_state_type state;
    fxe_state_type next_state;

    // Local register cache storage
    logic [31:0] cache_mem [0:NUM_SETS-1][0:REGS_PER_SET-1];
    logic [31:0] frame_ptr [0:NUM_SETS-1];
    logic [NUM_SETS-1:0] set_valid;
    logic [1:0]  walk_set;
    logic [3:0]  walk_reg;
    logic [31:0] reload_frame;

    // Datapath results
    wire logic [31:0] extract_result;
    wire logic        cond_raise;

    // Field pull datapath, purely combinational
    fxe_extract #(
        .W (fxe_pkg::DATA_W)
    ) u_extract (
        .src_dst (cmd_src_dst),
        .bitpos  (cmd_bitpos),
        .len     (cmd_len),
        .result  (extract_result)
    );

    // Fault condition test on the opcode mask
    fxe_fault_cond u_cond (
        .opcode_low           (cmd_opcode[fxe_pkg::MASK_LSB +: fxe_pkg::MASK_W]),
        .arith_condition_bits (arith_condition_bits),
        .raise                (cond_raise)
    );

    // Command decode
    wire logic take        = cmd_valid && (state == ST_IDLE);
    wire logic take_ext    = take && (cmd_op == fxe_pkg::FXE_OP_EXTRACT);
    wire logic take_fault  = take && (cmd_op == fxe_pkg::FXE_OP_FAULT);
    wire logic take_flush  = take && (cmd_op == fxe_pkg::FXE_OP_FLUSH);
    wire logic take_mark   = take && (cmd_op == fxe_pkg::FXE_OP_FMARK);
    wire logic take_ret    = take && (cmd_op == fxe_pkg::FXE_OP_RETURN);
    wire logic trace_on    = process_controls[fxe_pkg::TRACE_EN_POS];
    // Return target cached only if some valid set holds that frame
    logic ret_hit;
    always_comb begin
        ret_hit = 1'b0;
        for (int i = 0; i < NUM_SETS; i++) begin
            if (set_valid[i] && frame_ptr[i] == cmd_return_frame) begin
                ret_hit = 1'b1;
            end
        end
    end
    // Word address inside a frame; registers sit four bytes apart
    function automatic logic [31:0] word_addr(input logic [31:0] base, input logic [3:0] idx);
        word_addr = base + {26'h0, idx, 2'h0};
    endfunction

    // Walk control; current set never spilled
    wire logic walk_skip   = (walk_set == current_set) || !set_valid[walk_set];
    wire logic last_set    = (walk_set == 2'(NUM_SETS - 1));
    wire logic last_reg    = (walk_reg == 4'(REGS_PER_SET - 1));
    wire logic [31:0] walk_addr = word_addr(frame_ptr[walk_set], walk_reg);
    wire logic [31:0] reload_addr = word_addr(reload_frame, walk_reg);

    // Walk events; a skipped set still costs a scan cycle, traded for a simple scan
    wire logic scan_skip  = (state == ST_FLUSH_SCAN) && walk_skip;
    wire logic rd_acked   = (state == ST_RELOAD_RD) && mem_ack;
    wire logic word_acked = ((state == ST_FLUSH_WR) && mem_ack) || rd_acked;
    wire logic wr_set_end = (state == ST_FLUSH_WR) && mem_ack && last_reg;
    wire logic rd_end     = rd_acked && last_reg;
    // Purge once the scan leaves the last set, whether skipped or written
    wire logic purge_now  = (scan_skip || wr_set_end) && last_set;

    // Memory request selection; the address only moves on an acknowledge
    wire logic [3:0]  next_reg     = walk_reg + 4'h1;
    wire logic        wr_issue     = (next_state == ST_FLUSH_WR) && !(mem_ack && mem_req);
    wire logic        wr_advance   = (state == ST_FLUSH_WR) && mem_ack && !last_reg;
    wire logic        rd_issue     = (next_state == ST_RELOAD_RD);
    wire logic [31:0] next_wr_addr = word_addr(frame_ptr[walk_set], next_reg);
    wire logic [31:0] next_wr_data = cache_mem[walk_set][next_reg];
    wire logic [31:0] first_rd     = take ? cmd_return_frame : reload_addr;
    wire logic [31:0] rd_addr      = rd_acked ? reload_addr + 32'h4 : first_rd;

    // Pulse commands end one cycle after the take; spill and reload end from the done state
    wire logic quick_done = take && !take_flush && !(take_ret && !ret_hit);
    // Fault and marker raise only on their own command
    wire logic fault_hit  = take_fault && cond_raise;
    wire logic mark_hit   = take_mark && trace_on;

    // Ready only while idle; busy commands are refused, not queued
    assign cmd_ready = (state == ST_IDLE);
    assign set_valid_out = 4'(set_valid);

    // Next state selection
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (take_flush) begin
                    next_state = ST_FLUSH_SCAN;
                end else if (take_ret && !ret_hit) begin
                    next_state = ST_RELOAD_RD;
                end
            end
            ST_FLUSH_SCAN: begin
                if (!walk_skip) begin
                    next_state = ST_FLUSH_WR;
                end else if (last_set) begin
                    next_state = ST_DONE;
                end
            end
            ST_FLUSH_WR: begin
                if (mem_ack && last_reg) begin
                    next_state = last_set ? ST_DONE : ST_FLUSH_SCAN;
                end
            end
            ST_RELOAD_RD: begin
                if (mem_ack && last_reg) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Walk counters over sets and registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            walk_set     <= 2'h0;
            walk_reg     <= 4'h0;
            reload_frame <= fxe_pkg::RESET_DATA;
        end else if (take) begin
            walk_set     <= 2'h0;
            walk_reg     <= 4'h0;
            reload_frame <= cmd_return_frame;
        end else if (scan_skip && !last_set) begin
            walk_set <= walk_set + 2'h1;
        end else if (word_acked) begin
            walk_reg <= next_reg;
            // Next set only after the last word of this one
            if (wr_set_end && !last_set) begin
                walk_set <= walk_set + 2'h1;
            end
        end
    end

    // Cache valid bits; a fill or reload in the purge cycle is kept, the set wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            set_valid <= '0;
        end else begin
            if (purge_now) begin
                set_valid <= '0;
            end
            if (rd_end) begin
                set_valid[current_set] <= 1'b1;
            end
            if (fill_we) begin
                set_valid[fill_set] <= 1'b1;
            end
        end
    end

    // Cache contents; the reload lands in the current set, a core fill is never dropped
    always_ff @(posedge clk) begin
        if (rd_acked) begin
            cache_mem[current_set][walk_reg] <= mem_rdata;
            frame_ptr[current_set]           <= reload_frame;
        end
        if (fill_we) begin
            cache_mem[fill_set][fill_reg] <= fill_data;
            frame_ptr[fill_set]           <= fill_frame;
        end
    end

    // Memory request outputs, held until acknowledged
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_req   <= 1'b0;
            mem_write <= 1'b0;
            mem_addr  <= fxe_pkg::RESET_DATA;
            mem_wdata <= fxe_pkg::RESET_DATA;
        end else if (wr_issue) begin
            mem_req   <= 1'b1;
            mem_write <= 1'b1;
            mem_addr  <= walk_addr;
            mem_wdata <= cache_mem[walk_set][walk_reg];
        end else if (wr_advance) begin
            mem_req   <= 1'b1;
            mem_addr  <= next_wr_addr;
            mem_wdata <= next_wr_data;
        end else if (rd_issue) begin
            mem_req   <= 1'b1;
            mem_write <= 1'b0;
            mem_addr  <= rd_addr;
        end else begin
            mem_req   <= 1'b0;
            mem_write <= 1'b0;
        end
    end

    // Instruction pulses; fault and marker write nothing back
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done             <= 1'b0;
            result_we        <= 1'b0;
            range_fault      <= 1'b0;
            mark_trace_fault <= 1'b0;
        end else begin
            done             <= quick_done || (state == ST_DONE);
            result_we        <= take_ext;
            // range fault raise; no register write
            range_fault      <= fault_hit;
            mark_trace_fault <= mark_hit;
        end
    end

    // Field result holds until the next field pull
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_data <= fxe_pkg::RESET_DATA;
        end else if (take_ext) begin
            result_data <= extract_result;
        end
    end
endmodule
`default_nettype wire

// ### tb/fxe_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fxe_chk #(
    parameter int unsigned NUM_SETS     = 4,
    parameter int unsigned REGS_PER_SET = 16
) (
    // Clock and reset
    input wire logic                clk,
    input wire logic                rst_n,
    // Command side
    input wire logic                cmd_valid,
    input wire logic                cmd_ready,
    input wire fxe_pkg::fxe_op_type cmd_op,
    input wire logic [7:0]          cmd_opcode,
    input wire logic [31:0]         cmd_src_dst,
    input wire logic [31:0]         cmd_bitpos,
    input wire logic [31:0]         cmd_len,
    input wire logic [2:0]          arith_condition_bits,
    input wire logic [31:0]         process_controls,
    // Results and memory
    input wire logic                done,
    input wire logic [31:0]         result_data,
    input wire logic                result_we,
    input wire logic                range_fault,
    input wire logic                mark_trace_fault,
    input wire logic                mem_req,
    input wire logic [31:0]         mem_addr,
    input wire logic                mem_ack,
    input wire logic [3:0]          set_valid_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Accepted commands by kind
    wire tk   = cmd_valid && cmd_ready;
    wire tk_x = tk && cmd_op == fxe_pkg::FXE_OP_EXTRACT;
    wire tk_f = tk && cmd_op == fxe_pkg::FXE_OP_FAULT;
    wire tk_m = tk && cmd_op == fxe_pkg::FXE_OP_FMARK;
    wire tk_s = tk && cmd_op == fxe_pkg::FXE_OP_FLUSH;
    a_pull_value: assert property (tk_x && cmd_len < 32 |=> result_we && result_data ==
        (($past(cmd_src_dst) >> $past(cmd_bitpos[4:0])) & ((32'h1 << $past(cmd_len[4:0])) - 32'h1)))
        else $error("field pull result wrong");
    a_fault_mask_and: assert property (tk_f && cmd_opcode[2:0] != 3'h0 |=> range_fault ==
        (($past(cmd_opcode[2:0]) & $past(arith_condition_bits)) != 3'h0))
        else $error("masked fault decision wrong");
    a_unordered_zero: assert property (tk_f && cmd_opcode[2:0] == 3'h0 |=>
        range_fault == ($past(arith_condition_bits) == 3'h0)) else $error("unordered fault wrong");
    a_fault_from_cmd: assert property (range_fault |-> done && $past(tk_f))
        else $error("range fault without fault command");
    a_mark_on_enable: assert property (tk_m |=> mark_trace_fault == $past(process_controls[0]))
        else $error("mark trace fault wrong");
    a_mark_from_cmd: assert property (mark_trace_fault |-> $past(tk_m))
        else $error("mark trace fault without command");
    a_no_reg_write: assert property (tk_f || tk_m |=> done && !result_we)
        else $error("fault command wrote a register");
    a_spill_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("spill request dropped early");
    a_purge_after: assert property (tk_s |-> ##[1:1000] (done && set_valid_out == 4'h0))
        else $error("cache not purged after spill");
    c_spill: cover property (tk_s ##[1:400] done);
    c_range: cover property (range_fault);
    c_mark: cover property (mark_trace_fault);
endmodule
bind fxe_top fxe_chk #(.NUM_SETS(NUM_SETS), .REGS_PER_SET(REGS_PER_SET)) u_fxe_chk (
    .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_opcode(cmd_opcode), .cmd_src_dst(cmd_src_dst), .cmd_bitpos(cmd_bitpos),
    .cmd_len(cmd_len), .arith_condition_bits(arith_condition_bits),
    .process_controls(process_controls), .done(done), .result_data(result_data),
    .result_we(result_we), .range_fault(range_fault), .mark_trace_fault(mark_trace_fault),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .set_valid_out(set_valid_out));
`default_nettype wire

// ### tb/fxe_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fxe_top_tb;
    logic                clk, rst_n, cmd_valid, fill_we, mem_ack, cmd_ready, done;
    logic                result_we, range_fault, mark_trace_fault, mem_req, mem_write, rf, mf, we;
    fxe_pkg::fxe_op_type cmd_op;
    logic [7:0]          cmd_opcode;
    logic [31:0]         cmd_src_dst, cmd_bitpos, cmd_len, cmd_return_frame, process_controls;
    logic [31:0]         fill_data, fill_frame, mem_rdata, mem_addr, mem_wdata, result_data, a;
    logic [2:0]          arith_condition_bits;
    logic [1:0]          current_set, fill_set, wcnt;
    logic [3:0]          fill_reg, set_valid_out;
    logic [31:0]         mem [logic [31:0]];
    int                  n_wr, n_rd, n_mismatch, samples_checked;
    fxe_top u_fxe_top (.*);
    // Free-running core clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One command, then wait boundedly for its done pulse
    task automatic issue(input fxe_pkg::fxe_op_type op, input logic [7:0] opc);
        int k;
        k = 0;
        while (cmd_ready !== 1'b1) @(negedge clk);
        cmd_op = op;
        cmd_opcode = opc;
        cmd_valid = 1'b1;
        @(posedge clk);
        @(negedge clk);
        cmd_valid = 1'b0;
        while (done !== 1'b1 && k < 600) begin
            @(negedge clk);
            k++;
        end
        if (k == 600) n_mismatch++;
        rf = range_fault;
        mf = mark_trace_fault;
        we = result_we;
    endtask
    function automatic logic [31:0] ex(input logic [31:0] s, input logic [31:0] p, input int l);
        ex = (s >> p[4:0]) & ((l >= 32) ? 32'hFFFF_FFFF : ((32'h1 << l) - 32'h1));
    endfunction
    task automatic wrap_up();
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Stack memory: answers after two idle cycles so the spill sees a slow far side
    always @(negedge clk) begin
        if (mem_ack || !mem_req) begin
            mem_ack <= 1'b0;
            wcnt <= 2'h0;
            mem_rdata <= ~mem_rdata;
        end else if (wcnt == 2'h2) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem_addr ^ 32'h5A5A_0000;
            if (mem_write) begin
                mem[mem_addr] = mem_wdata;
                n_wr++;
            end else n_rd++;
        end else wcnt <= wcnt + 2'h1;
    end
    // Hang guard, well beyond the expected run
    initial begin
        #300000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        {rst_n, cmd_valid, fill_we, mem_ack, cmd_opcode, cmd_src_dst, cmd_bitpos} = '0;
        {cmd_len, cmd_return_frame, process_controls, fill_data, fill_frame} = '0;
        {arith_condition_bits, current_set, fill_set, fill_reg, wcnt} = '0;
        mem_rdata = 32'hA5A5_A5A5;
        cmd_op = fxe_pkg::FXE_OP_NONE;
        repeat (8) @(negedge clk);
        check(32'(set_valid_out), 32'h0);
        rst_n = 1'b1;
        for (int i = 0; i < 5; i++) begin
            cmd_src_dst = 32'hDEAD_BEEF ^ (32'h1357 * i);
            cmd_bitpos = (i == 1) ? 32'h24 : 32'(i * 7);
            cmd_len = (i == 2) ? 32'h20 : 32'(12 - 3 * i);
            issue(fxe_pkg::FXE_OP_EXTRACT, 8'h00);
            check(result_data, ex(cmd_src_dst, cmd_bitpos, int'(cmd_len)));
            check(32'(we), 32'h1);
        end
        for (int m = 0; m < 8; m++) begin
            for (int c = 0; c < 8; c++) begin
                arith_condition_bits = 3'(c);
                issue(fxe_pkg::FXE_OP_FAULT, {2'h3, 3'(c), 3'(m)});
                check(32'(rf), (m == 0) ? 32'(c == 0) : 32'((m & c) != 0));
                check(32'(we), 32'h0);
            end
        end
        // forced marker follows bit 0 only
        for (int i = 0; i < 4; i++) begin
            process_controls = (i > 1) ? 32'hFFFF_FFFE | 32'(i & 1) : 32'(i);
            issue(fxe_pkg::FXE_OP_FMARK, 8'h00);
            check(32'(mf), 32'(i & 1));
        end
        // fill every set, spill all but the current one
        for (int s = 0; s < 4; s++) begin
            for (int r = 0; r < 16; r++) begin
                {fill_we, fill_set, fill_reg} = {1'b1, 2'(s), 4'(r)};
                fill_frame = 32'h1000 * (s + 1);
                fill_data = 32'hC0DE_0000 + 32'(s * 256 + r);
                @(negedge clk);
            end
        end
        fill_we = 1'b0;
        check(32'(set_valid_out), 32'hF);
        current_set = 2'h1;
        issue(fxe_pkg::FXE_OP_FLUSH, 8'h00);
        check(32'(n_wr), 32'h30);
        check(32'(set_valid_out), 32'h0);
        check(32'(mem.exists(32'h2000)), 32'h0);
        for (int s = 0; s < 4; s++) begin
            for (int r = 0; r < 16; r++) begin
                a = 32'h1000 * (s + 1) + 32'(4 * r);
                if (s != 1) check(mem[a], 32'hC0DE_0000 + 32'(s * 256 + r));
            end
        end
        // far return only after a spill; uncached frame reloads
        cmd_return_frame = 32'h8000;
        issue(fxe_pkg::FXE_OP_RETURN, 8'h00);
        check(32'(n_rd), 32'h10);
        // frame now cached, so a second return reads nothing
        issue(fxe_pkg::FXE_OP_RETURN, 8'h00);
        check(32'(n_rd), 32'h10);
        // Empty command only finishes, raising nothing
        issue(fxe_pkg::FXE_OP_NONE, 8'h00);
        check(32'({rf, mf, we}), 32'h0);
        current_set = 2'h2;
        n_wr = 0;
        issue(fxe_pkg::FXE_OP_FLUSH, 8'h00);
        check(32'(n_wr), 32'h10);
        for (int r = 0; r < 16; r++) begin
            a = 32'h8000 + 32'(4 * r);
            check(mem[a], a ^ 32'h5A5A_0000);
        end
        wrap_up();
    end
endmodule
`default_nettype wire
